// file: bdv_top.sv
// dynamic voltage stepper for the buck rails with apb registers
// Summary of operation
// RULE1 - each rail level is a 7-bit code, one step 10 mV or 25 mV
// RULE2 - internal code moves one step per 3 us (10 mV) or 6 us (25 mV)
// RULE3 - step pacing keeps slew at or above 2.5 mV per us
// RULE4 - scaling forces pwm unless output decay select is set
// RULE5 - power good is masked while a rail is scaling
// RULE6 - code zero slews to 0.5 V then stops switching
// RULE7 - code above one while off restarts at 0.5 V, soft-start, then slews
// RULE8 - step range is a strap, frozen after reset, not writable
// RULE9 - per-rail mode bit picks auto pwm/pfm or forced pwm
// RULE10 - new code mid-transition continues stepping from current code
//
// Implementation choices: the address map and the APB register port.
`default_nettype none

module bdv_top
    import bdv_pkg::*;
#(
    parameter int NUM_RAILS = 6,
    parameter int SOFT_CYC  = SOFT_START_CYC
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic [11:0]           paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    // factory step range strap, one bit per rail, high for 25 mV
    input  wire logic [NUM_RAILS-1:0]  range_25mv_strap,
    // raw power good from the rail comparators
    input  wire logic [NUM_RAILS-1:0]  pg_raw,
    // to the analog loops
    output var  logic [NUM_RAILS*CODE_W-1:0] rail_voltage_code,
    output var  logic [NUM_RAILS-1:0]  force_pwm,
    output var  logic [NUM_RAILS-1:0]  switching_en,
    output var  logic [NUM_RAILS-1:0]  soft_start,
    output var  logic [NUM_RAILS-1:0]  power_good_indicator,
    // interrupt
    output var  logic                  irq
);

    localparam int SOFT_W = $clog2(SOFT_CYC + 1);

    // per-rail state
    bdv_state_t          state_q   [NUM_RAILS];
    logic [CODE_W-1:0]   cur_q     [NUM_RAILS];
    logic [CODE_W-1:0]   tgt_q     [NUM_RAILS];
    logic [SOFT_W-1:0]   soft_cnt_q[NUM_RAILS];
    logic [NUM_RAILS-1:0] mode_q;
    logic [NUM_RAILS-1:0] decay_q;
    logic [NUM_RAILS-1:0] sw_q;
    logic [NUM_RAILS-1:0] done;
    logic [NUM_RAILS-1:0] active;
    logic [NUM_RAILS-1:0] force_pwm_q;
    logic [NUM_RAILS-1:0] pg_ind_q;
    logic [NUM_RAILS-1:0] range_q;
    logic                 range_cap_q;
    logic [NUM_RAILS-1:0] irq_status_q;
    logic [NUM_RAILS-1:0] irq_mask_q;
    logic                 irq_q;
    logic                 tick_10mv;
    logic                 tick_25mv;

    // bus
    logic        setup;
    logic        access;
    logic        wr_en;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_d;
    logic        mapped_d;
    logic [2:0]  idx;
    logic        idx_ok;

    assign setup  = psel & ~penable;
    assign access = psel & penable & pready_q;
    assign wr_en  = access & pwrite & ~pslverr_q;
    assign idx    = paddr[4:2];
    assign idx_ok = int'(idx) < NUM_RAILS;

    // step interval enables shared by all rails
    bdv_tick_gen #(
        .CYC_10MV (STEP_10MV_CYC),
        .CYC_25MV (STEP_25MV_CYC)
    ) u_tick (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick_10mv (tick_10mv),
        .tick_25mv (tick_25mv)
    );

    // strap caught once at the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_q     <= '0;
            range_cap_q <= 1'b0;
        end else if (!range_cap_q) begin
            range_q     <= range_25mv_strap; // [RULE8]
            range_cap_q <= 1'b1;
        end
    end

    // read mux and address decode, sampled in the setup cycle
    always_comb begin
        rdata_d  = 32'h0000_0000;
        mapped_d = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            mapped_d = 1'b0;
        end else if (paddr[11:5] == RAIL_CTRL_BASE[11:5] && idx_ok) begin
            mapped_d = 1'b1;
            rdata_d[CODE_W-1:0]    = tgt_q[idx];
            rdata_d[CTRL_MODE_BIT]  = mode_q[idx];
            rdata_d[CTRL_DECAY_BIT] = decay_q[idx];
        end else if (paddr[11:5] == RAIL_STAT_BASE[11:5] && idx_ok) begin
            mapped_d = 1'b1;
            rdata_d[CODE_W-1:0]     = cur_q[idx];
            rdata_d[STAT_ACTIVE_BIT] = active[idx];
            rdata_d[STAT_SW_BIT]     = sw_q[idx];
            rdata_d[STAT_SOFT_BIT]   = (state_q[idx] == ST_SOFT);
            rdata_d[STAT_RANGE_BIT]  = range_q[idx];
        end else if (paddr == IRQ_STATUS_OFS) begin
            mapped_d = 1'b1;
            rdata_d[NUM_RAILS-1:0] = irq_status_q;
        end else if (paddr == IRQ_MASK_OFS) begin
            mapped_d = 1'b1;
            rdata_d[NUM_RAILS-1:0] = irq_mask_q;
        end else if (paddr == PG_STATUS_OFS) begin
            mapped_d = 1'b1;
            rdata_d[NUM_RAILS-1:0] = pg_ind_q;
        end
    end

    // apb answer: ready in the access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= ~mapped_d;
                prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
            end else if (access) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;

    // interrupt status: a completion in the clearing cycle still sets the bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= '0;
            irq_mask_q   <= '0;
            irq_q        <= 1'b0;
        end else begin
            if (wr_en && paddr == IRQ_STATUS_OFS) begin
                irq_status_q <= (irq_status_q & ~pwdata[NUM_RAILS-1:0]) | done;
            end else begin
                irq_status_q <= irq_status_q | done;
            end
            if (wr_en && paddr == IRQ_MASK_OFS) begin
                irq_mask_q <= pwdata[NUM_RAILS-1:0];
            end
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    assign irq = irq_q;

    genvar g;
    generate
        for (g = 0; g < NUM_RAILS; g++) begin : g_rail
            logic [CODE_W-1:0] goal;
            logic [CODE_W-1:0] half;
            logic              tick;
            logic              ctrl_wr;
            logic [8:0]        gap_q;

            assign half    = bdv_half_code(range_q[g]);
            // zero parks at the half-volt level before switching stops
            assign goal    = (tgt_q[g] == CODE_OFF) ? half : tgt_q[g]; // [RULE6]
            assign tick    = range_q[g] ? tick_25mv : tick_10mv; // [RULE2] [RULE3]
            assign ctrl_wr = wr_en && paddr[11:5] == RAIL_CTRL_BASE[11:5]
                             && int'(idx) == g;
            assign active[g] = (state_q[g] == ST_SLEW) || (state_q[g] == ST_SOFT);
            assign rail_voltage_code[g*CODE_W +: CODE_W] = cur_q[g];

            // software side of the rail control word
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tgt_q[g]   <= RESET_CODE;
                    mode_q[g]  <= 1'b0;
                    decay_q[g] <= 1'b0;
                end else if (ctrl_wr) begin
                    tgt_q[g]   <= pwdata[CODE_W-1:0]; // [RULE1]
                    mode_q[g]  <= pwdata[CTRL_MODE_BIT]; // [RULE9]
                    decay_q[g] <= pwdata[CTRL_DECAY_BIT];
                end
            end

            // sequencer; always chases the live target, so a rewrite simply redirects it
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    state_q[g]    <= ST_OFF;
                    cur_q[g]      <= CODE_OFF;
                    sw_q[g]       <= 1'b0;
                    soft_cnt_q[g] <= '0;
                    done[g]       <= 1'b0;
                end else begin
                    done[g] <= 1'b0;
                    unique case (state_q[g])
                        ST_IDLE: begin
                            if (goal != cur_q[g]) begin
                                state_q[g] <= ST_SLEW;
                            end else if (tgt_q[g] == CODE_OFF) begin
                                state_q[g] <= ST_OFF; // [RULE6]
                                cur_q[g]   <= CODE_OFF;
                                sw_q[g]    <= 1'b0;
                                done[g]    <= 1'b1;
                            end
                        end
                        ST_SLEW: begin
                            if (cur_q[g] == goal) begin
                                done[g] <= 1'b1;
                                if (tgt_q[g] == CODE_OFF) begin
                                    state_q[g] <= ST_OFF; // [RULE6]
                                    cur_q[g]   <= CODE_OFF;
                                    sw_q[g]    <= 1'b0;
                                end else begin
                                    state_q[g] <= ST_IDLE;
                                end
                            end else if (tick) begin
                                // single-code steps only, never a jump [RULE10] [RULE2]
                                cur_q[g] <= (goal > cur_q[g]) ? cur_q[g] + 7'h01
                                                              : cur_q[g] - 7'h01;
                            end
                        end
                        ST_OFF: begin
                            // code one while off keeps the rail off
                            if (range_cap_q && tgt_q[g] > CODE_MIN) begin
                                state_q[g]    <= ST_SOFT; // [RULE7]
                                cur_q[g]      <= half;
                                sw_q[g]       <= 1'b1;
                                soft_cnt_q[g] <= SOFT_W'(SOFT_CYC - 1);
                            end
                        end
                        ST_SOFT: begin
                            if (soft_cnt_q[g] == '0) begin
                                state_q[g] <= ST_SLEW; // [RULE7]
                            end else begin
                                soft_cnt_q[g] <= soft_cnt_q[g] - SOFT_W'(1);
                            end
                        end
                    endcase
                end
            end

            // loop mode and power good reporting, one cycle behind the state
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    force_pwm_q[g] <= 1'b0;
                    pg_ind_q[g]    <= 1'b0;
                end else begin
                    force_pwm_q[g] <= mode_q[g] | (active[g] & ~decay_q[g]); // [RULE4] [RULE9]
                    pg_ind_q[g]    <= pg_raw[g] & ~active[g]; // [RULE5]
                end
            end

            // cycles since the last step while a slew is pending
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gap_q <= '0;
                end else if (state_q[g] != ST_SLEW || cur_q[g] == goal || tick) begin
                    gap_q <= '0;
                end else begin
                    gap_q <= gap_q + 9'h001;
                end
            end

            a_step_one_code: assert property ( // [RULE10]
                @(posedge pclk) disable iff (!presetn)
                (state_q[g] == ST_SLEW) && (cur_q[g] != goal) |=>
                    (cur_q[g] == $past(cur_q[g])) || (cur_q[g] == $past(cur_q[g]) + 7'h01)
                    || (cur_q[g] == $past(cur_q[g]) - 7'h01))
                else $error("rail code moved by more than one step");

            a_step_on_tick: assert property ( // [RULE2]
                @(posedge pclk) disable iff (!presetn)
                (state_q[g] == ST_SLEW) && (cur_q[g] != goal) && !tick |=> $stable(cur_q[g]))
                else $error("rail code stepped without its interval enable");

            a_slew_rate_min: assert property ( // [RULE3]
                @(posedge pclk) disable iff (!presetn)
                range_q[g] ? (gap_q < 9'd240) : (gap_q < 9'd120))
                else $error("step interval too long for minimum slew");

            a_pwm_forced: assert property ( // [RULE4]
                @(posedge pclk) disable iff (!presetn)
                active[g] && !decay_q[g] |=> force_pwm_q[g])
                else $error("pwm not forced during scaling");

            a_decay_keeps_mode: assert property ( // [RULE4]
                @(posedge pclk) disable iff (!presetn)
                active[g] && decay_q[g] && !mode_q[g] |=> !force_pwm_q[g])
                else $error("decay select did not keep configured mode");

            a_pg_masked: assert property ( // [RULE5]
                @(posedge pclk) disable iff (!presetn)
                active[g] |=> !pg_ind_q[g])
                else $error("power good reported during scaling");

            a_zero_stops: assert property ( // [RULE6]
                @(posedge pclk) disable iff (!presetn)
                (state_q[g] == ST_SLEW) && (tgt_q[g] == CODE_OFF) && (cur_q[g] == half)
                |=> (state_q[g] == ST_OFF) && !sw_q[g] && (cur_q[g] == CODE_OFF))
                else $error("code zero did not stop switching at half volt");

            a_restart_half: assert property ( // [RULE7]
                @(posedge pclk) disable iff (!presetn)
                (state_q[g] == ST_OFF) ##1 (state_q[g] == ST_SOFT) |->
                    (cur_q[g] == half) && sw_q[g])
                else $error("restart did not begin at half volt");

            a_range_frozen: assert property ( // [RULE8]
                @(posedge pclk) disable iff (!presetn)
                range_cap_q |=> $stable(range_q[g]))
                else $error("step range changed after capture");

            a_mode_forces: assert property ( // [RULE9]
                @(posedge pclk) disable iff (!presetn)
                mode_q[g] |=> force_pwm_q[g])
                else $error("forced pwm mode bit ignored");

            c_reach_target: cover property (
                @(posedge pclk) disable iff (!presetn)
                (state_q[g] == ST_SLEW) ##1 (state_q[g] == ST_IDLE));

            c_enter_off: cover property (
                @(posedge pclk) disable iff (!presetn)
                (state_q[g] == ST_SLEW) ##1 (state_q[g] == ST_OFF));

            c_soft_restart: cover property (
                @(posedge pclk) disable iff (!presetn)
                (state_q[g] == ST_SOFT) ##1 (state_q[g] == ST_SLEW));
        end
    endgenerate

    // outputs taken from the per-rail flops
    assign force_pwm            = force_pwm_q;
    assign switching_en         = sw_q;
    assign power_good_indicator = pg_ind_q;

    // soft-start flag per rail, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_start <= '0;
        end else begin
            for (int i = 0; i < NUM_RAILS; i++) begin
                soft_start[i] <= (state_q[i] == ST_SOFT);
            end
        end
    end

endmodule : bdv_top

`default_nettype wire

// file: bdv_pkg.sv
// constants, field layout and state encoding of the buck voltage stepper
`default_nettype none

package bdv_pkg;

    // clock
    localparam int CLK_PERIOD_NS = 25;

    // step interval per range, nominal figures
    localparam int STEP_10MV_NS  = 3000;
    localparam int STEP_25MV_NS  = 6000;
    localparam int STEP_10MV_CYC = STEP_10MV_NS / CLK_PERIOD_NS;
    localparam int STEP_25MV_CYC = STEP_25MV_NS / CLK_PERIOD_NS;

    // soft-start wait after a restart from below the half-volt level
    localparam int SOFT_START_US  = 24;
    localparam int SOFT_START_CYC = (SOFT_START_US * 1000) / CLK_PERIOD_NS;

    // codes
    localparam int         CODE_W          = 7;
    localparam logic [6:0] CODE_OFF        = 7'h00;
    localparam logic [6:0] CODE_MIN        = 7'h01;
    localparam logic [6:0] HALF_CODE_10MV  = 7'h0a;
    localparam logic [6:0] HALF_CODE_25MV  = 7'h04;
    localparam logic [6:0] RESET_CODE      = 7'h00;

    // register byte offsets
    localparam logic [11:0] RAIL_CTRL_BASE = 12'h000;
    localparam logic [11:0] RAIL_STAT_BASE = 12'h020;
    localparam logic [11:0] IRQ_STATUS_OFS = 12'h040;
    localparam logic [11:0] IRQ_MASK_OFS   = 12'h044;
    localparam logic [11:0] PG_STATUS_OFS  = 12'h048;

    // field positions
    localparam int CTRL_MODE_BIT   = 8;
    localparam int CTRL_DECAY_BIT  = 9;
    localparam int STAT_ACTIVE_BIT = 8;
    localparam int STAT_SW_BIT     = 9;
    localparam int STAT_SOFT_BIT   = 10;
    localparam int STAT_RANGE_BIT  = 11;

    // per-rail sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SLEW = 2'b01,
        ST_OFF  = 2'b10,
        ST_SOFT = 2'b11
    } bdv_state_t;

    // code of the half-volt level for a given step range
    function automatic logic [6:0] bdv_half_code(input logic range_25mv);
        return range_25mv ? HALF_CODE_25MV : HALF_CODE_10MV;
    endfunction : bdv_half_code

endpackage : bdv_pkg

`default_nettype wire

// file: bdv_tick_gen.sv
// step interval divider producing one-cycle enables for both ranges
`default_nettype none

module bdv_tick_gen
    import bdv_pkg::*;
#(
    parameter int CYC_10MV = STEP_10MV_CYC,
    parameter int CYC_25MV = STEP_25MV_CYC
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // enables
    output var  logic tick_10mv,
    output var  logic tick_25mv
);

    localparam int CNT_W = $clog2(CYC_25MV);

    logic [CNT_W-1:0] cnt_q;

    // one free-running counter; the short interval divides the long one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (cnt_q == CNT_W'(CYC_25MV - 1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // enables registered so they are glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_10mv <= 1'b0;
            tick_25mv <= 1'b0;
        end else begin
            tick_10mv <= (cnt_q == CNT_W'(CYC_10MV - 1)) || (cnt_q == CNT_W'(CYC_25MV - 1));
            tick_25mv <= (cnt_q == CNT_W'(CYC_25MV - 1));
        end
    end

endmodule : bdv_tick_gen

`default_nettype wire

// file: bdv_rail_model.sv
// behavioural stand-in for the analog loops: reports power good
`default_nettype none

module bdv_rail_model
    import bdv_pkg::*;
#(
    parameter int NUM_RAILS = 6
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // from the stepper
    input  wire logic [NUM_RAILS*CODE_W-1:0] rail_voltage_code,
    input  wire logic [NUM_RAILS-1:0]        switching_en,
    // to the stepper
    output var  logic [NUM_RAILS-1:0]        pg_raw
);
    timeunit 1ns;
    timeprecision 1ps;

    // output settles one cycle after switching starts; a stopped or zero-code rail is never good
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_raw <= '0;
        end else begin
            for (int i = 0; i < NUM_RAILS; i++) begin
                pg_raw[i] <= switching_en[i] && (rail_voltage_code[i*CODE_W +: CODE_W] != '0);
            end
        end
    end
endmodule : bdv_rail_model

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the buck voltage stepper
`default_nettype none

module tb_top
    import bdv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  strap = 6'h2a;
    logic [5:0]  pg_raw;
    logic [41:0] rail_voltage_code;
    logic [5:0]  force_pwm;
    logic [5:0]  switching_en;
    logic [5:0]  soft_start;
    logic [5:0]  power_good_indicator;
    logic        irq;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc = 0;
    logic [31:0] q;
    logic        err;
    int          gap;

    always #12.5 pclk = ~pclk;

    bdv_top #(.NUM_RAILS(6), .SOFT_CYC(10)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .range_25mv_strap(strap),
        .pg_raw(pg_raw), .rail_voltage_code(rail_voltage_code),
        .force_pwm(force_pwm), .switching_en(switching_en),
        .soft_start(soft_start), .power_good_indicator(power_good_indicator),
        .irq(irq));

    bdv_rail_model #(.NUM_RAILS(6)) loop_model (
        .pclk(pclk), .presetn(presetn), .rail_voltage_code(rail_voltage_code),
        .switching_en(switching_en), .pg_raw(pg_raw));

    task automatic final_report;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // hang guard: the whole sequence needs under two thousand cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high, hang left to the guard
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [6:0] code_of(input int r);
        return rail_voltage_code[7*r +: 7];
    endfunction : code_of

    task automatic wait_code(input int r, input logic [6:0] c);
        int k;
        k = 0;
        while (code_of(r) !== c && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        chk("rail code", {25'h0, c}, {25'h0, code_of(r)});
    endtask : wait_code

    // cycles between reaching code c and reaching c+1
    task automatic step_gap(input int r, input logic [6:0] c);
        wait_code(r, c);
        gap = 0;
        while (code_of(r) === c && gap < 1000) begin
            @(posedge pclk);
            gap++;
        end
    endtask : step_gap

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, RAIL_CTRL_BASE, 32'h0);
        chk("ctrl reset", 32'h0, q);
        apb(1'b1, RAIL_STAT_BASE + 12'h004, 32'h0);
        apb(1'b0, RAIL_STAT_BASE + 12'h004, 32'h0);
        chk("range strap", 32'h800, q);
        apb(1'b0, 12'h04c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, IRQ_MASK_OFS, 32'h3f);
        // code one while off must not wake the rail
        apb(1'b1, RAIL_CTRL_BASE, 32'h01);
        repeat (20) @(posedge pclk);
        chk("stays off", 32'h0, {31'h0, switching_en[0]});
        apb(1'b1, RAIL_CTRL_BASE, 32'h0c);
        repeat (4) @(posedge pclk);
        chk("restart code", 32'h0a, {25'h0, code_of(0)});
        chk("soft start", 32'h1, {31'h0, soft_start[0]});
        chk("switching", 32'h1, {31'h0, switching_en[0]});
        chk("pwm forced", 32'h1, {31'h0, force_pwm[0]});
        chk("pg masked", 32'h0, {31'h0, power_good_indicator[0]});
        step_gap(0, 7'h0b);
        chk("gap 10mv", STEP_10MV_CYC, gap);
        chk("slew 10mv", 32'h1, {31'h0, gap * CLK_PERIOD_NS <= 4000});
        repeat (5) @(posedge pclk);
        chk("settled", 32'h0c, {25'h0, code_of(0)});
        chk("pg shown", 32'h1, {31'h0, power_good_indicator[0]});
        chk("auto mode", 32'h0, {31'h0, force_pwm[0]});
        chk("irq up", 32'h1, {31'h0, irq});
        apb(1'b1, IRQ_STATUS_OFS, 32'h01);
        apb(1'b0, IRQ_STATUS_OFS, 32'h0);
        chk("irq cleared", 32'h0, q);
        // redirect in mid-slew to a code already passed; must step back down to the new goal
        apb(1'b1, RAIL_CTRL_BASE, 32'h10);
        wait_code(0, 7'h0e);
        apb(1'b1, RAIL_CTRL_BASE, 32'h0d);
        repeat (300) @(posedge pclk);
        chk("redirect", 32'h0d, {25'h0, code_of(0)});
        apb(1'b1, IRQ_STATUS_OFS, 32'h3f);
        // 25 mV rail with decay select: mode kept during scaling
        apb(1'b1, RAIL_CTRL_BASE + 12'h004, 32'h206);
        wait_code(1, HALF_CODE_25MV);
        step_gap(1, 7'h05);
        chk("decay keeps mode", 32'h0, {31'h0, force_pwm[1]});
        chk("gap 25mv", STEP_25MV_CYC, gap);
        chk("slew 25mv", 32'h1, {31'h0, gap * CLK_PERIOD_NS <= 10000});
        apb(1'b1, RAIL_CTRL_BASE + 12'h004, 32'h106);
        repeat (3) @(posedge pclk);
        chk("forced mode", 32'h1, {31'h0, force_pwm[1]});
        // shutdown passes the half-volt code, then stops
        apb(1'b1, RAIL_CTRL_BASE, 32'h00);
        wait_code(0, HALF_CODE_10MV);
        wait_code(0, CODE_OFF);
        repeat (2) @(posedge pclk);
        chk("stopped", 32'h0, {31'h0, switching_en[0]});
        apb(1'b0, IRQ_STATUS_OFS, 32'h0);
        chk("done events", 32'h3, q);
        final_report();
    end
endmodule : tb_top

`default_nettype wire
